// file: power_monitor_low_power_ctrl.sv
// power controller: supply reset hold, supply monitor with hysteresis,
// sleep and stop sequencing, clock divider enables, AXI4-Lite registers
// assumes core, event controller and clock controller on the same MCLK;
// analog comparators and the reset pin arrive asynchronously
module power_monitor_low_power_ctrl
    import power_ctrl_pkg::*;
(
    // clock and power-on reset
    input wire logic MCLK,
    input wire logic RST,
    // AXI4-Lite slave
    input wire logic [31:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [31:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // analog supply comparators and reset pin
    input wire logic SUPPLY_ABOVE_LIMIT,
    input wire logic SUPPLY_ABOVE_FALL_THR,
    input wire logic SUPPLY_ABOVE_RISE_THR,
    output logic [2:0] THRESHOLD_SELECT,
    input wire logic EXT_RESET_PIN_I,
    output logic EXT_RESET_PIN_O,
    output logic EXT_RESET_PIN_OE_N,
    output logic SYSTEM_RESET,
    // monitor event line to the event controller
    output logic MONITOR_EVENT_LINE,
    // processor core
    input wire logic CORE_WFI,
    input wire logic CORE_WFE,
    input wire logic DEEP_SLEEP_SELECT,
    input wire logic IRQ_PENDING,
    input wire logic WAKE_EVENT,
    input wire logic EVENT_PENDING_ANY,
    // clock controller and regulator
    output logic CPU_CLK_EN,
    output logic PERIPH_CLK_EN,
    output logic SYS_CLK_TICK,
    output logic BUS_CLK_TICK,
    output logic PBUS_CLK_TICK,
    output logic SELECT_FAST_OSC,
    output logic REGULATOR_LOW_POWER,
    output logic IRQ
);
    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    sync_bus_if #(.W(SYN_W)) sb ();
    assign sb.raw[SYN_POR] = SUPPLY_ABOVE_LIMIT;
    assign sb.raw[SYN_PIN] = EXT_RESET_PIN_I;
    assign sb.raw[SYN_AFALL] = SUPPLY_ABOVE_FALL_THR;
    assign sb.raw[SYN_ARISE] = SUPPLY_ABOVE_RISE_THR;

    // comparators pass four flops before any edge is taken
    input_syncer #(.W(SYN_W)) u_sync (
        .clk(MCLK),
        .rst(RST),
        .sb(sb)
    );

    // ----------------------------------------------------------------
    // registers and bus state
    // ----------------------------------------------------------------
    logic [31:0] ctrl_q;
    logic [31:0] cdiv_q;
    logic [IRQ_W-1:0] irqs_q, irqs_d, irqm_q, irq_set;
    logic aw_got_q, w_got_q, bvalid_q, rvalid_q;
    logic [4:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    lp_state_t state_q, state_d;
    logic wfe_q, fast_osc_q, below_q, below_d, sysrst_q;
    logic [DIV_W-1:0] div_cnt_q [NUM_DIV];
    logic [NUM_DIV-1:0] tick;

    // ----------------------------------------------------------------
    // write channel decode
    // ----------------------------------------------------------------
    wire wr_fire = aw_got_q && w_got_q && !bvalid_q;
    wire wr_ctrl = wr_fire && (awaddr_q == OFS_CTRL);
    wire wr_cdiv = wr_fire && (awaddr_q == OFS_CDIV);
    wire wr_irqs = wr_fire && (awaddr_q == OFS_IRQS);
    wire wr_irqm = wr_fire && (awaddr_q == OFS_IRQM);
    wire wr_ok = wr_ctrl || wr_cdiv || wr_irqs || wr_irqm || (awaddr_q == OFS_STAT);
    wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    assign S_AXI_AWREADY = !aw_got_q && !bvalid_q;
    assign S_AXI_WREADY = !w_got_q && !bvalid_q;
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;

    // address and data latch independently; response follows both
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            bvalid_q <= 1'b0;
            awaddr_q <= 5'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bresp_q <= RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_got_q <= 1'b1;
                awaddr_q <= S_AXI_AWADDR[4:0];
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_got_q <= 1'b1;
                wdata_q <= S_AXI_WDATA;
                wstrb_q <= S_AXI_WSTRB;
            end
            if (wr_fire) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_ok ? RESP_OKAY
                                 : RESP_SLVERR;
            end else if (bvalid_q && S_AXI_BREADY) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // software-writable registers; enable and threshold steer the monitor
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            ctrl_q <= CTRL_RST;
            cdiv_q <= CDIV_RST;
            irqm_q <= IRQ_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= (ctrl_q & ~wmask) | (wdata_q & wmask);
            end
            if (wr_cdiv) begin
                cdiv_q <= (cdiv_q & ~wmask) | (wdata_q & wmask);
            end
            if (wr_irqm && wstrb_q[0]) begin
                irqm_q <= wdata_q[IRQ_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // read channel
    // ----------------------------------------------------------------
    wire [4:0] raddr = S_AXI_ARADDR[4:0];
    wire [31:0] stat_word = {{(31-STAT_MODE_LSB-1){1'b0}}, state_q, below_q};
    wire rd_hit = (raddr == OFS_CTRL) || (raddr == OFS_STAT) || (raddr == OFS_CDIV)
                  || (raddr == OFS_IRQS) || (raddr == OFS_IRQM);
    wire [31:0] rd_word = (raddr == OFS_CTRL) ? ctrl_q :
                          (raddr == OFS_STAT) ? stat_word :
                          (raddr == OFS_CDIV) ? cdiv_q :
                          (raddr == OFS_IRQS) ? {{(32-IRQ_W){1'b0}}, irqs_q} :
                          (raddr == OFS_IRQM) ? {{(32-IRQ_W){1'b0}}, irqm_q} : 32'h0000_0000;
    assign S_AXI_ARREADY = !rvalid_q;
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RDATA = rdata_q;
    assign S_AXI_RRESP = rresp_q;

    // one read at a time, answered the cycle after address is taken
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // supply monitor with hysteresis
    // ----------------------------------------------------------------
    wire mon_en = ctrl_q[CTRL_EN_BIT];
    assign THRESHOLD_SELECT = ctrl_q[CTRL_THR_LSB +: THR_W];
    // below falls on the low threshold, clears above the high one or while the monitor is disabled
    assign below_d = !mon_en ? 1'b0 :
                     !sb.lvl[SYN_AFALL] ? 1'b1 :
                     sb.lvl[SYN_ARISE] ? 1'b0 : below_q;
    wire ev_fell = below_d && !below_q;
    wire ev_rose = !below_d && below_q && mon_en;

    // monitor flag drives the event line directly
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            below_q <= 1'b0;
        end else begin
            below_q <= below_d;
        end
    end
    assign MONITOR_EVENT_LINE = below_q;

    // ----------------------------------------------------------------
    // supply reset hold and reset pin
    // ----------------------------------------------------------------
    // pin is pulled low while supply is below limit; a low pin also resets
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            sysrst_q <= 1'b1;
            EXT_RESET_PIN_OE_N <= 1'b0;
        end else begin
            sysrst_q <= !sb.lvl[SYN_POR] || !sb.lvl[SYN_PIN];
            EXT_RESET_PIN_OE_N <= sb.lvl[SYN_POR];
        end
    end
    assign EXT_RESET_PIN_O = 1'b0;
    assign SYSTEM_RESET = sysrst_q;

    // ----------------------------------------------------------------
    // low-power sequencer
    // ----------------------------------------------------------------
    wire lp_req = CORE_WFI || CORE_WFE;
    wire wake_now = wfe_q ? WAKE_EVENT : IRQ_PENDING;
    wire stop_skip = (state_q == ST_RUN) && lp_req && DEEP_SLEEP_SELECT && EVENT_PENDING_ANY;
    wire stop_exit = (state_q == ST_STOP) && wake_now;

    // next mode from core requests and wake sources
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_RUN: begin
                if (lp_req && DEEP_SLEEP_SELECT && !EVENT_PENDING_ANY) begin
                    state_d = ST_STOP;
                end else if (lp_req && !DEEP_SLEEP_SELECT) begin
                    state_d = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wake_now) begin
                    state_d = ST_RUN;
                end
            end
            ST_STOP: begin
                if (wake_now) begin
                    state_d = ST_RUN;
                end
            end
        endcase
    end

    // mode register; remembers WFE entry to pick the wake source
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            state_q <= ST_RUN;
            wfe_q <= 1'b0;
            fast_osc_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (state_q == ST_RUN && lp_req) begin
                wfe_q <= CORE_WFE && !CORE_WFI;
            end
            fast_osc_q <= stop_exit;
        end
    end

    // clock gates open in the very cycle a wake source arrives
    assign CPU_CLK_EN = (state_q == ST_RUN) || wake_now;
    assign PERIPH_CLK_EN = (state_q != ST_STOP) || wake_now;
    assign REGULATOR_LOW_POWER = (state_q == ST_STOP);
    assign SELECT_FAST_OSC = fast_osc_q;

    // ----------------------------------------------------------------
    // clock dividers
    // ----------------------------------------------------------------
    // divide by field+1; ticks halt with the peripheral clocks in stop
    generate
        for (genvar i = 0; i < NUM_DIV; i++) begin : g_div
            wire [DIV_W-1:0] div_val = cdiv_q[i*DIV_W +: DIV_W];
            assign tick[i] = PERIPH_CLK_EN && (div_cnt_q[i] == '0);
            always_ff @(posedge MCLK or posedge RST) begin
                if (RST) begin
                    div_cnt_q[i] <= '0;
                end else if (tick[i]) begin
                    div_cnt_q[i] <= div_val;
                end else if (PERIPH_CLK_EN) begin
                    div_cnt_q[i] <= div_cnt_q[i] - 1'b1;
                end
            end
        end
    endgenerate
    assign SYS_CLK_TICK = tick[0];
    assign BUS_CLK_TICK = tick[1];
    assign PBUS_CLK_TICK = tick[2];

    // ----------------------------------------------------------------
    // interrupt status and mask
    // ----------------------------------------------------------------
    assign irq_set = {stop_exit, stop_skip, ev_rose, ev_fell};
    // a new event in the clearing cycle survives the clear
    assign irqs_d = (irqs_q & ~((wr_irqs && wstrb_q[0]) ? wdata_q[IRQ_W-1:0] : 4'h0)) | irq_set;
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            irqs_q <= IRQ_RST;
        end else begin
            irqs_q <= irqs_d;
        end
    end
    assign IRQ = |(irqs_q & irqm_q);

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    a_monitor_off_quiet: assert property (!mon_en |=> !below_q)
        else $error("monitor flag set while disabled");
    a_thresh_drive_out: assert property (wr_ctrl && wstrb_q[0]
        |=> THRESHOLD_SELECT == $past(wdata_q[CTRL_THR_LSB +: THR_W]))
        else $error("threshold select not driven from control");
    a_flag_reads_back: assert property (rvalid_q && $past(S_AXI_ARREADY && S_AXI_ARVALID
        && raddr == OFS_STAT) |-> rdata_q[0] == $past(below_q))
        else $error("status read does not show monitor flag");
    a_fall_sets_irq: assert property ($rose(MONITOR_EVENT_LINE) |=> irqs_q[IRQ_FELL])
        else $error("fall event not recorded");
    a_hyst_holds_low: assert property (below_q && mon_en && sb.lvl[SYN_AFALL]
        && !sb.lvl[SYN_ARISE] |=> below_q)
        else $error("flag left hysteresis band early");
    a_reset_pin_low: assert property (!sb.lvl[SYN_POR] |=> SYSTEM_RESET && !EXT_RESET_PIN_OE_N)
        else $error("reset not held while supply low");
    a_reg_wake_normal: assert property (state_q == ST_STOP && wake_now
        |=> !REGULATOR_LOW_POWER && SELECT_FAST_OSC)
        else $error("regulator or oscillator wrong after wake");
    a_sleep_periph_run: assert property (state_q == ST_SLEEP |-> PERIPH_CLK_EN)
        else $error("peripherals stopped in sleep");
    a_stop_clocks_off: assert property (state_q == ST_STOP && !wake_now
        |-> !CPU_CLK_EN && !PERIPH_CLK_EN && !SYS_CLK_TICK)
        else $error("clocks running in stop");
    a_skip_stays_run: assert property (stop_skip |=> state_q == ST_RUN ##0 irqs_q[IRQ_SKIP])
        else $error("stop entered with pending flags");
    a_deep_goes_stop: assert property (state_q == ST_RUN && CORE_WFI && DEEP_SLEEP_SELECT
        && !EVENT_PENDING_ANY |=> state_q == ST_STOP)
        else $error("deep sleep request did not stop");
    a_div_period: assert property (BUS_CLK_TICK && cdiv_q[DIV_W +: DIV_W] == 4'h2 && !wr_cdiv
        ##1 PERIPH_CLK_EN [*2] |=> BUS_CLK_TICK || !PERIPH_CLK_EN)
        else $error("bus divider period wrong");

    c_sleep_wake: cover property (state_q == ST_SLEEP ##[1:20] state_q == ST_RUN);
    c_stop_wake: cover property (state_q == ST_STOP ##[1:60] SELECT_FAST_OSC);
    c_stop_skip: cover property (stop_skip);
    c_fall_rise: cover property ($rose(below_q) ##[1:50] $fell(below_q));
endmodule : power_monitor_low_power_ctrl

// file: power_ctrl_pkg.sv
// package of register map, field layout and state types for the power controller
// assumes a 32-bit AXI4-Lite register bus and one system clock
package power_ctrl_pkg;
    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [4:0] OFS_CTRL = 5'h00;  // power_control_reg
    localparam logic [4:0] OFS_STAT = 5'h04;  // power_control_status_reg
    localparam logic [4:0] OFS_CDIV = 5'h08;  // clock divider register
    localparam logic [4:0] OFS_IRQS = 5'h0c;  // sticky interrupt status, write one to clear
    localparam logic [4:0] OFS_IRQM = 5'h10;  // interrupt mask
    // ----------------------------------------------------------------
    // field positions and widths
    // ----------------------------------------------------------------
    localparam int CTRL_EN_BIT = 0;           // monitor_enable_bit
    localparam int CTRL_THR_LSB = 1;          // threshold_select
    localparam int THR_W = 3;
    localparam int STAT_FLAG_BIT = 0;         // monitor_output_flag
    localparam int STAT_MODE_LSB = 1;
    localparam int DIV_W = 4;                 // each divider field
    localparam int NUM_DIV = 3;               // system, bus, peripheral bus
    localparam int IRQ_W = 4;
    localparam int IRQ_FELL = 0;              // supply fell below threshold
    localparam int IRQ_ROSE = 1;              // supply rose above threshold
    localparam int IRQ_SKIP = 2;              // stop entry skipped
    localparam int IRQ_WAKE = 3;              // woke from stop
    // ----------------------------------------------------------------
    // reset values and bus answers
    // ----------------------------------------------------------------
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] CDIV_RST = 32'h0000_0000;
    localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ----------------------------------------------------------------
    // synchronised input bit positions
    // ----------------------------------------------------------------
    localparam int SYN_W = 4;
    localparam int SYN_POR = 0;               // supply above power_down_reset limit
    localparam int SYN_PIN = 1;               // external_reset_pin level
    localparam int SYN_AFALL = 2;             // supply above falling threshold
    localparam int SYN_ARISE = 3;             // supply above rising threshold
    // low-power modes
    typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_STOP} lp_state_t;
endpackage : power_ctrl_pkg

// file: sync_bus_if.sv
// interface carrying raw asynchronous levels and their cleaned versions
// assumes one clock on both ends
interface sync_bus_if #(parameter int W = 4);
    logic [W-1:0] raw;   // asynchronous pins
    logic [W-1:0] lvl;   // agreed level
    modport user (output raw, input lvl);
    modport syncer (input raw, output lvl);
endinterface : sync_bus_if

// file: input_syncer.sv
// three-stage synchroniser with agreement filter per bit
// assumes raw inputs come from outside the clock domain; lvl resets low
module input_syncer
    import power_ctrl_pkg::*;
#(
    parameter int W = SYN_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // levels in and out
    sync_bus_if.syncer sb
);
    generate
        for (genvar i = 0; i < W; i++) begin : g_bit
            logic s1_q, s2_q, s3_q, lvl_q;
            // first flop feeds only the second; change counts once stages 2 and 3 agree
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                    lvl_q <= 1'b0;
                end else begin
                    s1_q <= sb.raw[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        lvl_q <= s3_q;
                    end
                end
            end
            // filtered level; edges are taken downstream from this
            assign sb.lvl[i] = lvl_q;
        end
    endgenerate
endmodule : input_syncer

// file: core_partner.sv
// model of the core and event controller facing the power controller
// assumes one shared clock; go asks for WFI (1) or WFE (2) for one cycle
module core_partner (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // requests from the bench
    input wire logic [1:0] go,
    input wire logic [7:0] wake_dly,
    // power controller side
    input wire logic cpu_clk_en,
    output logic core_wfi,
    output logic core_wfe,
    output logic irq_pending,
    output logic wake_event
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] kind_q;
    logic [7:0] cnt_q;
    // one instruction pulse, then a wake source once the core clock stood still long enough
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {core_wfi, core_wfe, irq_pending, wake_event} <= 4'h0;
            kind_q <= 2'h0;
            cnt_q <= 8'h00;
        end else begin
            core_wfi <= (go == 2'h1);
            core_wfe <= (go == 2'h2);
            kind_q <= (go != 2'h0) ? go : kind_q;
            cnt_q <= (go != 2'h0) ? 8'h00 : (!cpu_clk_en && cnt_q != 8'hff) ? cnt_q + 8'h01 : cnt_q;
            irq_pending <= (kind_q == 2'h1) && !cpu_clk_en && (cnt_q >= wake_dly);
            wake_event <= (kind_q == 2'h2) && !cpu_clk_en && (cnt_q >= wake_dly);
        end
    end
endmodule : core_partner

// file: power_monitor_low_power_ctrl_tb.sv
// bench for the power controller: registers, monitor, reset hold, sleep and stop
// assumes the package and the core partner model are compiled first
module power_monitor_low_power_ctrl_tb
    import power_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
    logic lim = 1, fthr = 1, rthr = 1, ext_pin = 1, deep = 0, pend = 0, pin_i;
    logic awready, wready, bvalid, arready, rvalid, pin_o, pin_oe_n, sys_rst, evl, cpu_en, per_en;
    logic sys_tk, bus_tk, pbus_tk, fast_osc, reg_lp, irq, wfi, wfe, irqp, wake;
    logic [1:0] bresp, rresp, go = 0;
    logic [2:0] thr;
    logic [7:0] wake_dly = 8'h06;
    logic [3:0] wstrb = 4'hf;
    int fail_count = 0, comparisons = 0, n1;
    // clock and open-drain reset pin with pull-up
    always #25 clk = ~clk;
    assign pin_i = pin_oe_n ? ext_pin : pin_o;
    power_monitor_low_power_ctrl power_monitor_low_power_ctrl_inst (
        .MCLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .SUPPLY_ABOVE_LIMIT(lim), .SUPPLY_ABOVE_FALL_THR(fthr), .SUPPLY_ABOVE_RISE_THR(rthr),
        .THRESHOLD_SELECT(thr), .EXT_RESET_PIN_I(pin_i), .EXT_RESET_PIN_O(pin_o),
        .EXT_RESET_PIN_OE_N(pin_oe_n), .SYSTEM_RESET(sys_rst), .MONITOR_EVENT_LINE(evl),
        .CORE_WFI(wfi), .CORE_WFE(wfe), .DEEP_SLEEP_SELECT(deep), .IRQ_PENDING(irqp),
        .WAKE_EVENT(wake), .EVENT_PENDING_ANY(pend), .CPU_CLK_EN(cpu_en), .PERIPH_CLK_EN(per_en),
        .SYS_CLK_TICK(sys_tk), .BUS_CLK_TICK(bus_tk), .PBUS_CLK_TICK(pbus_tk),
        .SELECT_FAST_OSC(fast_osc), .REGULATOR_LOW_POWER(reg_lp), .IRQ(irq)
    );
    core_partner core_partner_inst (
        .clk(clk), .rst(rst), .go(go), .wake_dly(wake_dly), .cpu_clk_en(cpu_en),
        .core_wfi(wfi), .core_wfe(wfe), .irq_pending(irqp), .wake_event(wake)
    );
    // verdict and end of run
    task automatic stop_test();
        if (fail_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test
    // one comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic nw(input int n);
        repeat (n) @(negedge clk);
    endtask : nw
    // one AXI4-Lite write (w high) or read; d is write data or expected read data
    task automatic axi(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic ta, tw, td;
        @(posedge clk);
        if (w) begin
            {awaddr, wdata, awvalid, wvalid, bready} <= {27'h0, a, d, 3'b111};
        end else begin
            {araddr, arvalid, rready} <= {27'h0, a, 2'b11};
        end
        for (n = 0; n < 50; n++) begin
            @(negedge clk);
            ta = (awvalid & awready) | (arvalid & arready);
            tw = wvalid & wready;
            td = (bready & bvalid) | (rready & rvalid);
            if (td) begin
                chk(w ? bresp : rresp, er);
                chk(w ? d : rdata, d);
            end
            @(posedge clk);
            if (ta) {awvalid, arvalid} <= 2'b00;
            if (tw) wvalid <= 1'b0;
            if (td) begin
                {bready, rready} <= 2'b00;
                break;
            end
        end
        if (n == 50) begin
            fail_count++;
            stop_test();
        end
    endtask : axi
    // move supply comparators, then let the synchronisers settle
    task automatic sup(input logic f, input logic r);
        @(posedge clk);
        {fthr, rthr} <= {f, r};
        nw(8);
    endtask : sup
    // ask the partner for a sleep instruction, sample half a cycle after entry
    task automatic nap(input logic [1:0] k, input logic d, input logic p, input logic [7:0] dly);
        @(posedge clk);
        {go, deep, pend, wake_dly} <= {k, d, p, dly};
        @(posedge clk);
        go <= 2'h0;
        nw(2);
    endtask : nap
    // main sequence
    initial begin
        nw(4);
        chk({sys_rst, pin_oe_n, cpu_en, per_en, reg_lp}, 5'b10110);
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        nw(12);
        chk({sys_rst, pin_oe_n}, 2'b01);
        axi(1, 5'h14, 32'hffff_ffff, RESP_SLVERR);
        axi(0, 5'h14, 32'h0, RESP_SLVERR);
        for (int i = 0; i < 5; i++) axi(0, 5'(4 * i), 32'h0, RESP_OKAY);
        sup(0, 0);
        chk(evl, 0);
        axi(0, OFS_IRQS, 32'h0, RESP_OKAY);
        sup(1, 1);
        axi(1, OFS_CTRL, 32'hb, RESP_OKAY);
        chk(thr, 3'h5);
        wstrb <= 4'h0;
        axi(1, OFS_CTRL, 32'h0, RESP_OKAY);
        wstrb <= 4'hf;
        axi(0, OFS_CTRL, 32'hb, RESP_OKAY);
        sup(0, 0);
        chk(evl, 1);
        axi(0, OFS_STAT, 32'h1, RESP_OKAY);
        sup(1, 0);
        chk(evl, 1);
        sup(1, 1);
        chk({evl, irq}, 2'b00);
        axi(0, OFS_IRQS, 32'h3, RESP_OKAY);
        axi(1, OFS_IRQM, 32'h1, RESP_OKAY);
        nw(1);
        chk(irq, 1);
        axi(1, OFS_IRQS, 32'h1, RESP_OKAY);
        nw(1);
        chk(irq, 0);
        axi(0, OFS_IRQS, 32'h2, RESP_OKAY);
        axi(1, OFS_IRQS, 32'h2, RESP_OKAY);
        axi(1, OFS_IRQM, 32'h8, RESP_OKAY);
        axi(1, OFS_CDIV, 32'h320, RESP_OKAY);
        nw(4);
        n1 = 0;
        repeat (24) begin
            @(negedge clk);
            n1 += 64 * sys_tk + 8 * bus_tk + pbus_tk;
        end
        chk(n1, 24 * 64 + 8 * 8 + 6);
        axi(1, OFS_CDIV, 32'h0, RESP_OKAY);
        for (int k = 1; k < 3; k++) begin
            nap(2'(k), 0, 0, 8'h06);
            chk({cpu_en, per_en, reg_lp}, 3'b010);
            nw(12);
            chk(cpu_en, 1);
            nap(2'(k), 1, 0, 8'h28);
            chk({cpu_en, per_en, reg_lp}, 3'b001);
            axi(0, OFS_STAT, 32'h4, RESP_OKAY);
            n1 = 0;
            repeat (60) begin
                @(negedge clk);
                n1 += fast_osc;
            end
            chk({n1[1:0], cpu_en, reg_lp, irq}, 5'b01101);
            axi(0, OFS_IRQS, 32'h8, RESP_OKAY);
            axi(0, OFS_CTRL, 32'hb, RESP_OKAY);
            axi(1, OFS_IRQS, 32'hf, RESP_OKAY);
        end
        nap(1, 1, 1, 8'h06);
        chk(cpu_en, 1);
        axi(0, OFS_IRQS, 32'h4, RESP_OKAY);
        @(posedge clk);
        {pend, lim} <= 2'b00;
        nw(8);
        chk({sys_rst, pin_oe_n, pin_o}, 3'b100);
        @(posedge clk);
        lim <= 1'b1;
        nw(12);
        chk(sys_rst, 0);
        stop_test();
    end
endmodule : power_monitor_low_power_ctrl_tb
